// *** adc_irq_cfg.svh ***
// constants for the converter second-level and vectored top-level interrupt logic
`ifndef ADC_IRQ_CFG_SVH
`define ADC_IRQ_CFG_SVH

// register byte addresses
`define ADDR_FLAGS      32'h4000A810
`define ADDR_CFG        32'h4000A850
`define ADDR_MASK_SET   32'h4000A900
`define ADDR_MASK_CLR   32'h4000A904
`define ADDR_PEND_SET   32'h4000A908
`define ADDR_PEND_CLR   32'h4000A90C
`define ADDR_ACTIVE     32'h4000A910
`define ADDR_CTL_STATUS 32'h4000A914
`define ADDR_CTL_MASK   32'h4000A918
`define ADDR_PRIO_BASE  32'h4000A980
`define ADDR_VEC_BASE   32'h4000AB00
`define TABLE_BYTES     32'h00000084

// second-level flag and enable positions
`define BIT_OVF  4
`define BIT_SAT  3
`define BIT_FULL 2
`define BIT_HALF 1
`define BIT_DATA 0
`define SRC_W    5

// exception table shape
`define NUM_STD      16
`define NUM_PERIPH   17
`define NUM_EXC      33
`define FIRST_PERIPH 16
`define ADC_POS      27
`define STACK_POS    0
`define RESET_POS    1
`define FIXED_LAST   3
`define STD_VALID    16'hD87E
`define PRIO_W       5
`define POS_W        6

// controller status bits
`define ST_DISPATCH 0
`define ST_BOOT     1
`define CTL_W       2

`endif

// *** adc_irq_pkg.sv ***
// types shared by the interrupt logic
package adc_irq_pkg;

  // converter event strobes, bit order matches the flag register
  typedef struct packed {
    logic ovf;
    logic sat;
    logic full;
    logic half;
    logic data;
  } adc_events_t;

  // register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // exception handed to the core
  typedef struct packed {
    logic        valid;
    logic [5:0]  pos;
    logic [31:0] vector;
  } exc_out_t;

  // boot fetch handed to the core
  typedef struct packed {
    logic        valid;
    logic [31:0] sp;
    logic [31:0] pc;
  } boot_out_t;

  typedef struct packed {
    logic [4:0] flags;
    logic [4:0] cfg;
    logic       req;
  } flag_state_t;

  typedef struct packed {
    logic [16:0]       mask;
    logic [16:0]       pend;
    logic [32:0]       active;
    logic [32:0][4:0]  prio;
    logic [32:0][31:0] vec;
    logic [31:0]       rdata;
    exc_out_t          exc;
    boot_out_t         boot;
    logic              boot_done;
    logic [1:0]        ctl_status;
    logic [1:0]        ctl_mask;
    logic              irq;
  } top_state_t;

endpackage : adc_irq_pkg

// *** adc_event_flags.sv ***
// converter second-level pending flags, enables and combined request
`include "adc_irq_cfg.svh"

module adc_event_flags (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire adc_irq_pkg::adc_events_t events,
  input  wire logic                   wr_flags,
  input  wire logic                   wr_cfg,
  input  wire logic [4:0]             wdata,
  output logic      [4:0]             flags,
  output logic      [4:0]             cfg,
  output logic                        req
);

  adc_irq_pkg::flag_state_t st;
  adc_irq_pkg::flag_state_t next_st;

  // events set flags; a write of ones clears, a same-cycle event wins
  always_comb begin
    next_st = st;
    next_st.flags = (st.flags & ~(wr_flags ? wdata : 5'h00)) | events;
    if (wr_cfg) begin
      next_st.cfg = wdata;
    end
    next_st.req = |(st.flags & st.cfg);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;
  assign cfg   = st.cfg;
  assign req   = st.req;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  ovf_flag_a: assert property (events.ovf |=> flags[`BIT_OVF])
    else $error("overflow event lost");
  sat_flag_a: assert property (events.sat |=> flags[`BIT_SAT])
    else $error("saturation event lost");
  full_flag_a: assert property (events.full |=> flags[`BIT_FULL])
    else $error("buffer full event lost");
  half_flag_a: assert property (events.half |=> flags[`BIT_HALF])
    else $error("half full event lost");
  data_flag_a: assert property (events.data |=> flags[`BIT_DATA])
    else $error("data ready event lost");
  combined_req_a: assert property (|(flags & cfg) |=> req ##0 $past(|(flags & cfg)))
    else $error("request does not follow enabled flags");
  flag_clear_a: assert property (wr_flags && !(|events) |=> (flags & $past(wdata)) == 5'h00)
    else $error("written flag did not clear");

endmodule : adc_event_flags

// *** vectored_irq_top.sv ***
// vectored top-level interrupt controller with converter second level
//
// The plain strobed port was decided locally.
`include "adc_irq_cfg.svh"

module vectored_irq_top #(
  parameter logic [31:0] BOOT_SP = 32'h00000000,
  parameter logic [31:0] BOOT_PC = 32'h00000000
) (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire adc_irq_pkg::reg_req_t    reg_req,
  output logic      [31:0]              reg_rdata,
  input  wire adc_irq_pkg::adc_events_t adc_events,
  input  wire logic [15:0]              std_req,
  input  wire logic [16:0]              periph_req,
  input  wire logic                     core_ack,
  input  wire logic                     exc_done,
  input  wire logic [5:0]               exc_done_pos,
  output adc_irq_pkg::exc_out_t         exc,
  output adc_irq_pkg::boot_out_t        boot,
  output logic                          irq
);

  localparam int          NEXC    = `NUM_EXC;
  localparam int          NSTD    = `NUM_STD;
  localparam int          ADC_IDX = `ADC_POS - `FIRST_PERIPH;
  localparam logic [15:0] STD_OK  = `STD_VALID;

  adc_irq_pkg::top_state_t st;
  adc_irq_pkg::top_state_t next_st;

  logic [4:0]  adc_flags;
  logic [4:0]  adc_cfg;
  logic        adc_req;
  logic        wr_flags;
  logic        wr_cfg;
  logic [6:0]  prio_hit;
  logic [6:0]  vec_hit;
  logic        vec_wr;

  // table region decode: {hit, index}
  function automatic logic [6:0] table_hit(input logic [31:0] a, input logic [31:0] base);
    logic [31:0] off;
    off = a - base;
    table_hit = {(a >= base) && (off < `TABLE_BYTES) && (off[1:0] == 2'b00), off[7:2]};
  endfunction : table_hit

  // ordering key: fixed class first, then software level, then position
  function automatic logic [11:0] exc_key(input logic [5:0] pos, input logic [4:0] p);
    if (pos <= 6'(`FIXED_LAST)) begin
      exc_key = {1'b0, 5'h00, pos};
    end else begin
      exc_key = {1'b1, p, pos};
    end
  endfunction : exc_key

  // register strobes
  assign wr_flags = reg_req.wr && (reg_req.addr == `ADDR_FLAGS);
  assign wr_cfg   = reg_req.wr && (reg_req.addr == `ADDR_CFG);
  assign prio_hit = table_hit(reg_req.addr, `ADDR_PRIO_BASE);
  assign vec_hit  = table_hit(reg_req.addr, `ADDR_VEC_BASE);
  assign vec_wr   = reg_req.wr && vec_hit[6];

  adc_event_flags u_flags (
    .core_clk (core_clk),
    .nrst     (nrst),
    .events   (adc_events),
    .wr_flags (wr_flags),
    .wr_cfg   (wr_cfg),
    .wdata    (reg_req.wdata[4:0]),
    .flags    (adc_flags),
    .cfg      (adc_cfg),
    .req      (adc_req)
  );

  // whole controller: registers, pending latch, arbitration, boot fetch
  always_comb begin
    logic [16:0] lvl;
    logic [16:0] pset;
    logic [16:0] pclr;
    logic [11:0] best;
    logic [11:0] k;
    logic        found;
    logic        cand;
    logic [1:0]  ev;
    logic [1:0]  rclr;
    next_st = st;
    lvl     = periph_req;
    pset    = 17'h00000;
    pclr    = 17'h00000;
    best    = 12'hFFF;
    k       = 12'hFFF;
    found   = 1'b0;
    cand    = 1'b0;
    ev      = 2'h0;
    rclr    = 2'h0;
    lvl[ADC_IDX] = adc_req;

    // boot: one fetch of stack and reset entries after release
    next_st.boot.valid = 1'b0;
    if (!st.boot_done) begin
      next_st.boot_done  = 1'b1;
      next_st.boot.valid = 1'b1;
      next_st.boot.sp    = st.vec[`STACK_POS];
      next_st.boot.pc    = st.vec[`RESET_POS];
      ev[`ST_BOOT]       = 1'b1;
    end

    // core takes the offered exception
    if (st.exc.valid && core_ack) begin
      next_st.active[st.exc.pos] = 1'b1;
      next_st.exc.valid          = 1'b0;
      if (st.exc.pos >= 6'(`FIRST_PERIPH)) begin
        pclr[5'(st.exc.pos - 6'(`FIRST_PERIPH))] = 1'b1;
      end
    end
    if (exc_done && (exc_done_pos < 6'(NEXC))) begin
      next_st.active[exc_done_pos] = 1'b0;
    end

    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        `ADDR_MASK_SET: next_st.mask = st.mask | reg_req.wdata[16:0];
        `ADDR_MASK_CLR: next_st.mask = st.mask & ~reg_req.wdata[16:0];
        `ADDR_PEND_SET: pset = reg_req.wdata[16:0];
        `ADDR_PEND_CLR: pclr = pclr | reg_req.wdata[16:0];
        `ADDR_CTL_MASK: next_st.ctl_mask = reg_req.wdata[1:0];
        default: begin
          // fixed-priority entries keep level zero
          if (prio_hit[6] && prio_hit[5:0] > 6'(`FIXED_LAST)) begin
            next_st.prio[prio_hit[5:0]] = reg_req.wdata[4:0];
          end
          if (vec_hit[6]) begin
            next_st.vec[vec_hit[5:0]] = reg_req.wdata;
          end
        end
      endcase
    end

    // pending latch: level inputs re-set every cycle, set beats clear
    next_st.pend = (st.pend & ~pclr) | pset | lvl;

    // arbitration only while nothing is offered; lowest key wins
    if (!st.exc.valid && st.boot_done) begin
      for (int i = 1; i < NEXC; i++) begin
        if (i < NSTD) begin
          cand = std_req[i] && STD_OK[i];
        end else begin
          cand = st.pend[i - NSTD] && st.mask[i - NSTD];
        end
        k = exc_key(6'(i), st.prio[i]);
        if (cand && !st.active[i] && (!found || k < best)) begin
          best  = k;
          found = 1'b1;
        end
      end
      if (found) begin
        next_st.exc.valid  = 1'b1;
        next_st.exc.pos    = best[5:0];
        next_st.exc.vector = st.vec[best[5:0]];
        ev[`ST_DISPATCH]   = 1'b1;
      end
    end

    // read data one cycle later, zero when unmapped or idle
    next_st.rdata = 32'h00000000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `ADDR_FLAGS:      next_st.rdata = {27'h0000000, adc_flags};
        `ADDR_CFG:        next_st.rdata = {27'h0000000, adc_cfg};
        `ADDR_MASK_SET,
        `ADDR_MASK_CLR:   next_st.rdata = {15'h0000, st.mask};
        `ADDR_PEND_SET,
        `ADDR_PEND_CLR:   next_st.rdata = {15'h0000, st.pend};
        `ADDR_ACTIVE:     next_st.rdata = st.active[31:0];
        `ADDR_CTL_STATUS: begin
          next_st.rdata = {30'h00000000, st.ctl_status};
          rclr          = 2'h3;
        end
        `ADDR_CTL_MASK:   next_st.rdata = {30'h00000000, st.ctl_mask};
        default: begin
          if (prio_hit[6]) begin
            next_st.rdata = {27'h0000000, st.prio[prio_hit[5:0]]};
          end else if (vec_hit[6]) begin
            next_st.rdata = st.vec[vec_hit[5:0]];
          end
        end
      endcase
    end

    // sticky controller events, read clears, event in same cycle wins
    next_st.ctl_status = (st.ctl_status & ~rclr) | ev;
    next_st.irq        = |(next_st.ctl_status & next_st.ctl_mask);
  end

  // reset: table words cleared except the boot entries
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st                   <= '0;
      st.vec[`STACK_POS]   <= BOOT_SP;
      st.vec[`RESET_POS]   <= BOOT_PC;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign exc       = st.exc;
  assign boot      = st.boot;
  assign irq       = st.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  vector_load_a: assert property ($rose(st.exc.valid) && !$past(vec_wr)
      |-> st.exc.vector == st.vec[st.exc.pos])
    else $error("offered vector differs from table entry");
  stack_never_a: assert property (st.exc.valid |-> st.exc.pos != 6'd0 && st.exc.pos < 6'd33)
    else $error("invalid table position offered");
  reset_first_a: assert property ($rose(st.exc.valid) && $past(std_req[1])
      && !$past(st.active[1]) |-> st.exc.pos == 6'd1)
    else $error("reset not taken first");
  boot_pulse_a: assert property ($rose(st.boot_done) |-> st.boot.valid ##1 !st.boot.valid)
    else $error("boot fetch not a single pulse");
  mask_gate_a: assert property ($rose(st.exc.valid) && st.exc.pos == 6'd27
      |-> $past(st.mask[11]) && $past(st.pend[11]))
    else $error("converter interrupt taken while masked");
  level_pend_a: assert property (adc_req |=> st.pend[11])
    else $error("converter request not latched");
  level_input_a: assert property (periph_req[0] |=> st.pend[0])
    else $error("level request not latched");
  ack_active_a: assert property (st.exc.valid && core_ack
      |=> !st.exc.valid && st.active[$past(st.exc.pos)])
    else $error("acknowledge did not mark active");
  status_irq_a: assert property (st.irq == |(st.ctl_status & st.ctl_mask))
    else $error("interrupt output disagrees with status");

endmodule : vectored_irq_top

// *** core_model.sv ***
// processor core stand-in that takes offered exceptions and returns from them
module core_model (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire adc_irq_pkg::exc_out_t exc,
  input  wire logic [3:0]            lag,
  output logic                       core_ack,
  output logic                       exc_done,
  output logic [5:0]                 exc_done_pos,
  output logic [5:0]                 taken_pos,
  output logic [31:0]                pc,
  output int                         n_taken
);
  logic take;
  int   wait_n;
  int   busy_n;

  initial begin
    core_ack = 1'h0;
    exc_done = 1'h0;
    exc_done_pos = 6'h00;
    n_taken = 0;
    wait_n = 0;
    busy_n = 0;
  end

  // one handler at a time; the return comes 20 cycles after the take
  always @(posedge core_clk) begin
    take = nrst && busy_n == 0 && exc.valid && !core_ack && wait_n >= int'(lag);
    core_ack <= take;
    exc_done <= nrst && busy_n == 1;
    // an idle position bus toggles so stale values never look valid
    exc_done_pos <= (busy_n == 1) ? taken_pos : ~exc_done_pos;
    if (take) begin
      taken_pos <= exc.pos;
      pc <= exc.vector;
      n_taken <= n_taken + 1;
    end
    if (!nrst || take)
      wait_n = 0;
    else if (exc.valid && busy_n == 0)
      wait_n++;
    if (!nrst)
      busy_n = 0;
    else if (take)
      busy_n = 20;
    else if (busy_n > 0)
      busy_n--;
  end
endmodule : core_model

// *** adc_two_level_interrupt_logic_test.sv ***
// self-checking bench for the converter two-level interrupt logic
`include "adc_irq_cfg.svh"

module adc_two_level_interrupt_logic_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] SP0 = 32'h00001F00;
  localparam logic [31:0] PC0 = 32'h00000101;

  logic                     core_clk;
  logic                     nrst;
  adc_irq_pkg::reg_req_t    reg_req;
  logic [31:0]              reg_rdata;
  adc_irq_pkg::adc_events_t adc_events;
  logic [15:0]              std_req;
  logic [16:0]              periph_req;
  logic                     core_ack;
  logic                     exc_done;
  logic [5:0]               exc_done_pos;
  adc_irq_pkg::exc_out_t    exc;
  adc_irq_pkg::boot_out_t   boot;
  logic                     irq;
  logic [3:0]               lag;
  logic [5:0]               taken_pos;
  logic [31:0]              pc;
  logic [16:0]              lfsr = 17'h12F4B;
  int                       n_taken;
  int                       n_errors = 0;
  int                       tests_run = 0;
  int                       m_flags = 0;
  int                       k, p1, p2, q1, q2, win;

  vectored_irq_top #(.BOOT_SP(SP0), .BOOT_PC(PC0)) u_vectored_irq_top (
    .core_clk(core_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .adc_events(adc_events), .std_req(std_req), .periph_req(periph_req),
    .core_ack(core_ack), .exc_done(exc_done), .exc_done_pos(exc_done_pos),
    .exc(exc), .boot(boot), .irq(irq));

  core_model u_core_model (
    .core_clk(core_clk), .nrst(nrst), .exc(exc), .lag(lag), .core_ack(core_ack),
    .exc_done(exc_done), .exc_done_pos(exc_done_pos), .taken_pos(taken_pos),
    .pc(pc), .n_taken(n_taken));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return {15'h0000, lfsr};
  endfunction : rnd

  // vector word table entries 1 to 32 are loaded with
  function automatic logic [31:0] vec_of(int p);
    return 32'h00004000 | (32'(p) << 2);
  endfunction : vec_of

  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge core_clk);
    reg_req.wr <= 1'h0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(logic [31:0] a, logic [31:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 32'h00000000, wr: 1'h0, rd: 1'h1};
    @(posedge core_clk);
    reg_req.rd <= 1'h0;
    #1 check_val("reg_rdata", exp, reg_rdata);
  endtask : rd_chk

  task automatic pulse(logic [4:0] e);
    @(posedge core_clk);
    adc_events <= e;
    @(posedge core_clk);
    adc_events <= '0;
  endtask : pulse

  task automatic wait_exc(int k0, int p);
    int i;
    i = 0;
    while (n_taken <= k0 && i < 200) begin
      @(posedge core_clk);
      i++;
    end
    #1 check_val("exc_pos", 32'(p), {26'h0000000, taken_pos});
    check_val("exc_vector", vec_of(p), pc);
  endtask : wait_exc

  // handler epilogue: flags first, then the top latch once the level has dropped
  task automatic clear_adc();
    wr(`ADDR_FLAGS, 32'(m_flags));
    m_flags = 0;
    wr(`ADDR_PEND_CLR, 32'h00000800);
  endtask : clear_adc

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // 250 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  // watchdog, well beyond the roughly 700 cycles the run needs
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    nrst = 1'h0;
    reg_req = '0;
    adc_events = '0;
    std_req = 16'h0000;
    periph_req = 17'h00000;
    lag = 4'h0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (3) @(posedge core_clk);
    check_val("boot_sp", SP0, boot.sp);
    check_val("boot_pc", PC0, boot.pc);
    rd_chk(`ADDR_FLAGS, 32'h00000000);
    rd_chk(`ADDR_CFG, 32'h00000000);
    rd_chk(32'h4000A814, 32'h00000000);
    rd_chk(`ADDR_CTL_STATUS, 32'h00000002);
    wr(`ADDR_CFG, 32'hFFFFFFFF);
    rd_chk(`ADDR_CFG, 32'h0000001F);
    for (int p = 2; p < `NUM_EXC; p++)
      wr(`ADDR_VEC_BASE + 32'(4 * p), vec_of(p));
    wr(`ADDR_MASK_SET, 32'h0001FFFF);
    wr(`ADDR_CTL_MASK, 32'h00000001);
    // each converter source through both levels, core answering ever slower
    for (int b = 0; b < `SRC_W; b++) begin
      k = n_taken;
      lag <= 4'(3 * b);
      pulse(5'(1 << b));
      m_flags = m_flags | (1 << b);
      wait_exc(k, `ADC_POS);
      check_val("irq", 32'h00000001, {31'h00000000, irq});
      rd_chk(`ADDR_FLAGS, 32'(m_flags));
      clear_adc();
      rd_chk(`ADDR_CTL_STATUS, 32'h00000001);
      @(posedge core_clk);
      #1 check_val("irq", 32'h00000000, {31'h00000000, irq});
      repeat (25) @(posedge core_clk);
    end
    // disabled sources latch quietly, reserved core inputs are ignored
    lag <= 4'h0;
    k = n_taken;
    wr(`ADDR_CFG, 32'h00000000);
    std_req <= 16'h2781;
    pulse(5'h1F);
    m_flags = 32'h1F;
    repeat (12) @(posedge core_clk);
    check_val("n_taken", 32'(k), 32'(n_taken));
    rd_chk(`ADDR_FLAGS, 32'(m_flags));
    std_req <= 16'h0000;
    // pending without the top mask waits, then a late mask delivers
    wr(`ADDR_MASK_CLR, 32'h00000800);
    wr(`ADDR_CFG, 32'h00000004);
    repeat (8) @(posedge core_clk);
    check_val("n_taken", 32'(k), 32'(n_taken));
    rd_chk(`ADDR_PEND_CLR, 32'h00000800);
    wr(`ADDR_MASK_SET, 32'h00000800);
    wait_exc(k, `ADC_POS);
    clear_adc();
    repeat (25) @(posedge core_clk);
    // two peripherals at random priorities; first trial ties, last meets a fixed core one
    for (int t = 0; t < 4; t++) begin
      k = n_taken;
      p1 = rnd() % 16;
      p2 = (p1 + 1 + rnd() % 15) % 16;
      p1 = p1 + int'(p1 > 10);
      p2 = p2 + int'(p2 > 10);
      q1 = rnd() % 32;
      q2 = (t == 0) ? q1 : rnd() % 32;
      wr(`ADDR_PRIO_BASE + 32'(4 * (16 + p1)), 32'(q1));
      wr(`ADDR_PRIO_BASE + 32'(4 * (16 + p2)), 32'(q2));
      win = (q1 < q2 || (q1 == q2 && p1 < p2)) ? p1 : p2;
      @(posedge core_clk);
      periph_req <= 17'(1 << p1) | 17'(1 << p2);
      std_req <= (t == 3) ? 16'h0004 : 16'h0000;
      wait_exc(k, (t == 3) ? 2 : 16 + win);
      @(posedge core_clk);
      periph_req <= 17'h00000;
      std_req <= 16'h0000;
      wr(`ADDR_PEND_CLR, 32'h0001FFFF);
      repeat (50) @(posedge core_clk);
    end
    // reset request is offered a cycle before a software pend of a peripheral lands
    k = n_taken;
    wr(`ADDR_VEC_BASE + 32'h00000004, vec_of(1));
    @(posedge core_clk);
    std_req <= 16'h0002;
    wr(`ADDR_PEND_SET, 32'h00000001);
    wait_exc(k, 1);
    std_req <= 16'h0000;
    rd_chk(`ADDR_ACTIVE, 32'h00000002);
    repeat (50) @(posedge core_clk);
    finish_test();
  end
endmodule : adc_two_level_interrupt_logic_test
